// ### src/urxef_top.sv
// The register addresses and register access over APB are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - overrun set when unread data blocks transfer
// - overrun drops new character and its errors
// - status read then data read clears overrun
// - seven start samples, three per bit
// - disagreeing sample sets noise with full
// - status then data read clears noise
// - zero at stop sets framing error
// - status then data read clears framing
// - parity mismatch when enabled sets parity error
// - status then data read clears parity
// - flag one means condition occurred
// - full set on transfer, cleared by sequence
module urxef_top #(
	parameter int BAUD_DIV = urxef_pkg::BAUD_DIV_DEF
) (
	// clock and reset
	input  wire logic        SYS_CLK,
	input  wire logic        RST_N,
	// apb slave
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [7:0]  PADDR,
	input  wire logic [31:0] PWDATA,
	output logic      [31:0] PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	// serial line
	input  wire logic        RXD,
	// interrupt
	output logic             IRQ
);

	urxef_pkg::urxef_state_t state;     // receive state
	logic [15:0]             baud_cnt;  // oversample divider
	logic                    tick;      // oversample strobe
	logic [3:0]              sub;       // tick within bit
	logic [2:0]              bit_idx;   // data bit index
	logic [2:0]              smp;       // sample shift of bit
	logic [7:0]              shreg;     // data shifter
	logic                    noisy;     // noise seen in frame
	logic                    par_acc;   // running parity
	logic                    par_bad;   // parity mismatch
	logic                    done;      // frame finished pulse
	logic                    stop_zero; // stop bit sampled low
	urxef_pkg::urxef_char_t  held;      // data register contents
	logic                    full;      // receive full flag
	logic                    ovr;       // overrun flag
	logic                    armed;     // status read seen with flags
	logic [1:0]              ctrl;      // parity enable, odd
	logic [2:0]              irq_st;    // sticky events
	logic [2:0]              irq_mk;    // event mask
	logic                    acc;       // apb access phase
	logic                    rd_stat;   // status read strobe
	logic                    rd_data;   // data read strobe
	logic                    clr_seq;   // clearing sequence completes
	logic [7:0]              receive_line_status_one; // status byte
	logic                    maj;       // majority of three samples
	logic                    dis;       // samples disagree

	// address match helper, used by every strobe
	function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
		hit = (a == o);
	endfunction

	// apb decoding; always ready, no wait states
	assign acc     = PSEL && PENABLE;
	assign PREADY  = 1'b1;
	assign PSLVERR = 1'b0;
	assign rd_stat = acc && !PWRITE && hit(PADDR, urxef_pkg::STATUS_OFF);
	assign rd_data = acc && !PWRITE && hit(PADDR, urxef_pkg::DATA_OFF);
	assign clr_seq = rd_data && armed;

	// oversample tick at sixteen per bit
	always_ff @(posedge SYS_CLK) begin
		if (!RST_N || state == urxef_pkg::RX_IDLE) begin
			baud_cnt <= 16'h0000;
		end else if (baud_cnt == 16'(BAUD_DIV / 16 - 1)) begin
			baud_cnt <= 16'h0000;
		end else begin
			baud_cnt <= baud_cnt + 16'h0001;
		end
	end
	assign tick = (state != urxef_pkg::RX_IDLE) &&
		(baud_cnt == 16'(BAUD_DIV / 16 - 1));

	// three-sample majority and disagreement
	assign maj = (smp[0] & smp[1]) | (smp[1] & smp[2]) | (smp[0] & smp[2]);
	assign dis = !(smp == 3'h0 || smp == 3'h7);

	// a lone low sample starts a frame; a glitch then reads as noise
	// receive frame machine
	always_ff @(posedge SYS_CLK) begin
		done      <= 1'b0;
		stop_zero <= 1'b0;
		if (!RST_N) begin
			state   <= urxef_pkg::RX_IDLE;
			sub     <= 4'h0;
			bit_idx <= 3'h0;
			smp     <= 3'h0;
			shreg   <= 8'h00;
			noisy   <= 1'b0;
			par_acc <= 1'b0;
			par_bad <= 1'b0;
		end else begin
			case (state)
				urxef_pkg::RX_IDLE: begin
					// low level on the line starts a frame
					if (!RXD) begin
						state   <= urxef_pkg::RX_START;
						sub     <= 4'h0;
						noisy   <= 1'b0;
						par_bad <= 1'b0;
						par_acc <= ctrl[urxef_pkg::POD_BIT];
					end
				end
				urxef_pkg::RX_START: begin
					if (tick) begin
						sub <= sub + 4'h1;
						if (sub >= 4'h1 && sub <= 4'(urxef_pkg::START_SAMPLES)
							&& RXD) begin
							noisy <= 1'b1;
						end
						if (sub == urxef_pkg::TICKS_BIT) begin
							state   <= urxef_pkg::RX_DATA;
							bit_idx <= 3'h0;
						end
					end
				end
				default: begin
					if (tick) begin
						sub <= sub + 4'h1;
						if (sub == urxef_pkg::SMP_A || sub == urxef_pkg::SMP_B
							|| sub == urxef_pkg::SMP_C) begin
							smp <= {smp[1:0], RXD};
						end
						if (sub == urxef_pkg::TICKS_BIT) begin
							if (dis) begin
								noisy <= 1'b1;
							end
							case (state)
								urxef_pkg::RX_DATA: begin
									shreg   <= {maj, shreg[7:1]};
									par_acc <= par_acc ^ maj;
									bit_idx <= bit_idx + 3'h1;
									if (bit_idx == 3'h7) begin
										state <= ctrl[urxef_pkg::PEN_BIT] ?
											urxef_pkg::RX_PAR :
											urxef_pkg::RX_STOP;
									end
								end
								urxef_pkg::RX_PAR: begin
									par_bad <= par_acc ^ maj;
									state   <= urxef_pkg::RX_STOP;
								end
								default: begin
									stop_zero <= !maj;
									done      <= 1'b1;
									state     <= urxef_pkg::RX_IDLE;
								end
							endcase
						end
					end
				end
			endcase
		end
	end

	// a clear and an arrival together: the new character loads
	// data register, full flag and error flags
	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			held <= '0;
			full <= 1'b0;
		end else if (done && (!full || clr_seq)) begin
			full        <= 1'b1;
			held.data   <= shreg;
			held.noise  <= noisy;
			held.frame  <= stop_zero;
			held.parity <= par_bad;
		end else if (clr_seq) begin
			full        <= 1'b0;
			held.noise  <= 1'b0;
			held.frame  <= 1'b0;
			held.parity <= 1'b0;
		end
	end

	// overrun flag; a clearing data read in the same cycle
	// frees the register, so the arrival loads instead
	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			ovr <= 1'b0;
		end else if (done && full && !clr_seq) begin
			ovr <= 1'b1;
		end else if (clr_seq) begin
			ovr <= 1'b0;
		end
	end

	// any data read disarms, so a stale status read never clears
	// status read arms the clearing sequence
	always_ff @(posedge SYS_CLK) begin
		if (!RST_N || rd_data) begin
			armed <= 1'b0;
		end else if (rd_stat && (full || ovr)) begin
			armed <= 1'b1;
		end
	end

	// status byte, one bit per condition
	always_comb begin
		receive_line_status_one = urxef_pkg::STATUS_RST;
		receive_line_status_one[urxef_pkg::FULL_BIT]   = full;
		receive_line_status_one[urxef_pkg::OVR_BIT]    = ovr;
		receive_line_status_one[urxef_pkg::NOISE_BIT]  = held.noise;
		receive_line_status_one[urxef_pkg::FRAME_BIT]  = held.frame;
		receive_line_status_one[urxef_pkg::PARITY_BIT] = held.parity;
	end

	// control and mask writes; status writes ignored
	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			ctrl   <= urxef_pkg::CTRL_RST;
			irq_mk <= urxef_pkg::IRQ_RST;
		end else if (acc && PWRITE) begin
			if (hit(PADDR, urxef_pkg::CTRL_OFF)) begin
				ctrl <= PWDATA[1:0];
			end
			if (hit(PADDR, urxef_pkg::IRQ_MK_OFF)) begin
				irq_mk <= PWDATA[2:0];
			end
		end
	end

	// sticky events, write one clears, set wins
	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			irq_st <= urxef_pkg::IRQ_RST;
		end else begin
			for (int i = 0; i < 3; i++) begin
				if (acc && PWRITE && hit(PADDR, urxef_pkg::IRQ_ST_OFF)
					&& PWDATA[i]) begin
					irq_st[i] <= 1'b0;
				end
			end
			if (done && (!full || clr_seq)) begin
				irq_st[urxef_pkg::IRQ_CHAR] <= 1'b1;
				if (noisy || stop_zero || par_bad) begin
					irq_st[urxef_pkg::IRQ_ERR] <= 1'b1;
				end
			end
			if (done && full && !clr_seq) begin
				irq_st[urxef_pkg::IRQ_OVR] <= 1'b1;
			end
		end
	end

	// read data loaded in setup, so it stands through access
	// registered read data and interrupt
	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			PRDATA <= 32'h0000_0000;
			IRQ    <= 1'b0;
		end else begin
			IRQ <= |(irq_st & irq_mk);
			if (PSEL && !PENABLE && !PWRITE) begin
				case (PADDR)
					urxef_pkg::STATUS_OFF: PRDATA <= {24'h0,
						receive_line_status_one};
					urxef_pkg::DATA_OFF:   PRDATA <= {24'h0, held.data};
					urxef_pkg::CTRL_OFF:   PRDATA <= {30'h0, ctrl};
					urxef_pkg::IRQ_ST_OFF: PRDATA <= {29'h0, irq_st};
					urxef_pkg::IRQ_MK_OFF: PRDATA <= {29'h0, irq_mk};
					default:               PRDATA <= 32'h0000_0000;
				endcase
			end
		end
	end

endmodule

`default_nettype wire

// ### src/urxef_pkg.sv
package urxef_pkg;

	// register byte offsets
	localparam logic [7:0] STATUS_OFF = 8'h00;
	localparam logic [7:0] DATA_OFF   = 8'h04;
	localparam logic [7:0] CTRL_OFF   = 8'h08;
	localparam logic [7:0] IRQ_ST_OFF = 8'h0c;
	localparam logic [7:0] IRQ_MK_OFF = 8'h10;

	// status field positions
	localparam int PARITY_BIT = 0;
	localparam int FRAME_BIT  = 1;
	localparam int NOISE_BIT  = 2;
	localparam int OVR_BIT    = 3;
	localparam int FULL_BIT   = 5;

	// control field positions
	localparam int PEN_BIT = 0;
	localparam int POD_BIT = 1;

	// interrupt status layout
	localparam int IRQ_CHAR = 0;
	localparam int IRQ_ERR  = 1;
	localparam int IRQ_OVR  = 2;

	// reset values
	localparam logic [7:0] STATUS_RST = 8'h00;
	localparam logic [1:0] CTRL_RST   = 2'h0;
	localparam logic [2:0] IRQ_RST    = 3'h0;

	// sampling: 16 ticks per bit, samples 7..9 of data/stop
	localparam int BAUD_DIV_DEF = 1302;
	localparam logic [3:0] TICKS_BIT = 4'hf;
	localparam int START_SAMPLES = 7;
	localparam int BIT_SAMPLES   = 3;
	localparam logic [3:0] SMP_A = 4'h7;
	localparam logic [3:0] SMP_B = 4'h8;
	localparam logic [3:0] SMP_C = 4'h9;

	// receive states
	typedef enum logic [2:0] {
		RX_IDLE,
		RX_START,
		RX_DATA,
		RX_PAR,
		RX_STOP
	} urxef_state_t;

	// one received character with its error indications
	typedef struct packed {
		logic [7:0] data;
		logic       noise;
		logic       frame;
		logic       parity;
	} urxef_char_t;

endpackage

// ### test/urxef_checker.sv
`timescale 1ns/1ps
`default_nettype none
module urxef_checker #(
	parameter int BAUD_DIV = 64
) (
	// clock, reset
	input wire logic        SYS_CLK,
	input wire logic        RST_N,
	// apb
	input wire logic        PSEL,
	input wire logic        PENABLE,
	input wire logic        PWRITE,
	input wire logic [7:0]  PADDR,
	input wire logic [31:0] PRDATA,
	input wire logic        PREADY,
	input wire logic        PSLVERR,
	// line
	input wire logic        RXD
);
	logic        st;   // status read access
	logic        dt;   // data read access
	logic [15:0] idle; // cycles the line stayed high
	logic [5:0]  last; // flags at last status read
	logic        held; // no data read since then
	assign st = PSEL && PENABLE && !PWRITE && PADDR == urxef_pkg::STATUS_OFF;
	assign dt = PSEL && PENABLE && !PWRITE && PADDR == urxef_pkg::DATA_OFF;
	// a long idle line means no frame can land mid-sequence
	always_ff @(posedge SYS_CLK) begin
		if (!RST_N || !RXD) begin
			idle <= 16'h0;
		end else if (idle != 16'hffff) begin
			idle <= idle + 16'h1;
		end
	end
	// flags may only rise until a data read
	always_ff @(posedge SYS_CLK) begin
		if (!RST_N || dt) begin
			held <= 1'b0;
		end else if (st) begin
			held <= 1'b1;
			last <= PRDATA[5:0];
		end
	end
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (!RST_N);
	sequence arm_clear;
		st && PRDATA[5] ##2 dt && int'(idle) > 12 * BAUD_DIV;
	endsequence
	rsvd_zero_a:
		assert property (st |-> PRDATA[31:6] == 26'h0 && !PRDATA[4])
		else $error("reserved status bits set");
	ovr_full_a:
		assert property (st && PRDATA[3] |-> PRDATA[5])
		else $error("overrun without full");
	noise_full_a:
		assert property (st && PRDATA[2] |-> PRDATA[5])
		else $error("noise without full");
	frame_full_a:
		assert property (st && PRDATA[1] |-> PRDATA[5])
		else $error("framing without full");
	parity_full_a:
		assert property (st && PRDATA[0] |-> PRDATA[5])
		else $error("parity without full");
	flag_hold_a:
		assert property (st && held |-> (PRDATA[5:0] & last) == last)
		else $error("flag lost without data read");
	clear_seq_a:
		assert property (arm_clear ##2 st |-> PRDATA[5:0] == 6'h0)
		else $error("flags survive clear");
	rdata_hold_a:
		assert property (PSEL && PENABLE && !PWRITE |=> $stable(PRDATA)
			&& PREADY && !PSLVERR)
		else $error("read data moved after access");
endmodule
bind urxef_top urxef_checker #(.BAUD_DIV(BAUD_DIV)) i_chk (
	.SYS_CLK(SYS_CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE),
	.PWRITE(PWRITE), .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY),
	.PSLVERR(PSLVERR), .RXD(RXD)
);
`default_nettype wire

// ### test/urxef_tx_model.sv
`timescale 1ns/1ps
`default_nettype none
module urxef_tx_model #(
	parameter int BAUD_DIV = 64
) (
	// clock
	input  wire logic clk,
	// line, idles high
	output var logic  rxd
);
	initial rxd = 1'b1;
	// one bit; nz flips a single middle sample
	task automatic bit_out(input logic v, input logic nz);
		rxd <= v;
		repeat (BAUD_DIV / 2 - 2) @(posedge clk);
		rxd <= v ^ nz;
		repeat (4) @(posedge clk);
		rxd <= v;
		repeat (BAUD_DIV / 2 - 2) @(posedge clk);
	endtask
	// short low pulse on an idle line, then a long idle
	task automatic glitch;
		rxd <= 1'b0;
		repeat (2) @(posedge clk);
		rxd <= 1'b1;
		repeat (BAUD_DIV * 11) @(posedge clk);
	endtask
	// m: 0 parity, 1 odd, 2 bad parity, 3 stop low, 4 noise
	task automatic send(input logic [7:0] d, input logic [4:0] m);
		bit_out(1'b0, 1'b0);
		for (int i = 0; i < 8; i++) begin
			bit_out(d[i], m[4] && i == 0);
		end
		if (m[0]) begin
			bit_out(^d ^ m[1] ^ m[2], 1'b0);
		end
		// low stop cut short, else its tail looks like a start
		rxd <= !m[3];
		repeat (BAUD_DIV * 3 / 4) @(posedge clk);
		rxd <= 1'b1;
		repeat (BAUD_DIV / 2) @(posedge clk);
	endtask
endmodule
`default_nettype wire

// ### test/urxef_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module urxef_tb_top;
	localparam int BD = 64; // short bit time
	localparam logic [7:0] ST = urxef_pkg::STATUS_OFF;
	localparam logic [7:0] MK = urxef_pkg::IRQ_MK_OFF;
	logic        clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0;
	logic        pwrite = 1'b0, pready, pslverr, rxd, irq;
	logic [7:0]  paddr = 8'h0;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	int          fails = 0, samples_checked = 0;
	always #2.5 clk = ~clk;
	urxef_top #(.BAUD_DIV(BD)) i_dut (
		.SYS_CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable),
		.PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
		.PREADY(pready), .PSLVERR(pslverr), .RXD(rxd), .IRQ(irq)
	);
	urxef_tx_model #(.BAUD_DIV(BD)) i_tx (.clk(clk), .rxd(rxd));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// psel stays up so a next setup may follow at once
	task automatic xf(input logic w, input logic [7:0] a, logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do
			@(posedge clk);
		while (pready !== 1'b1);
		rd = prdata;
		penable <= 1'b0;
	endtask
	task automatic rel;
		psel <= 1'b0;
		repeat (3) @(posedge clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xf(1'b1, a, d);
		rel();
	endtask
	// poll status until flag b shows
	task automatic wait_st(input int b);
		do
			xf(1'b0, ST, 32'h0);
		while (rd[b] !== 1'b1);
		rel();
	endtask
	// idle line, then status, data, status back to back
	task automatic clr(input logic [7:0] s, input logic [7:0] d);
		repeat (13 * BD) @(posedge clk);
		xf(1'b0, ST, 32'h0);
		chk(rd, {24'h0, s});
		xf(1'b0, urxef_pkg::DATA_OFF, 32'h0);
		chk(rd, {24'h0, d});
		xf(1'b0, ST, 32'h0);
		chk(rd, 32'h0);
		rel();
	endtask
	task automatic t_basic;
		xf(1'b0, 8'h20, 32'h0);
		chk(rd, 32'h0);
		wr(MK, 32'h1);
		i_tx.send(8'ha5, 5'h0);
		wait_st(5);
		chk({31'h0, irq}, 32'h1);
		wr(MK, 32'h0);
		chk({31'h0, irq}, 32'h0);
		wr(urxef_pkg::IRQ_ST_OFF, 32'h7);
		wr(MK, 32'h7);
		chk({31'h0, irq}, 32'h0);
		clr(8'h20, 8'ha5);
		$display("basic receive done");
	endtask
	// noise, framing, bad even parity, good odd parity
	task automatic t_err;
		logic [4:0] md [4] = '{5'h10, 5'h08, 5'h05, 5'h03};
		logic [7:0] ex [4] = '{8'h24, 8'h22, 8'h21, 8'h20};
		for (int i = 0; i < 4; i++) begin
			wr(urxef_pkg::CTRL_OFF, {30'h0, md[i][1:0]});
			i_tx.send(8'h5a + 8'(i), md[i]);
			wait_st(5);
			// status writes must leave the flags alone
			wr(ST, 32'hff);
			clr(ex[i], 8'h5a + 8'(i));
		end
		$display("error flags done");
	endtask
	// second, noisy char must vanish with its flag
	task automatic t_ovr;
		wr(urxef_pkg::CTRL_OFF, 32'h0);
		i_tx.send(8'h11, 5'h0);
		wait_st(5);
		i_tx.send(8'h22, 5'h10);
		wait_st(3);
		clr(8'h28, 8'h11);
		$display("overrun done");
	endtask
	// false start: ones with noise, framing flag stays clear
	task automatic t_glitch;
		i_tx.glitch();
		wait_st(5);
		clr(8'h24, 8'hff);
		$display("glitch frame done");
	endtask
	task automatic stop_test;
		$display("checked %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	initial begin
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		t_basic();
		t_err();
		t_ovr();
		t_glitch();
		stop_test();
	end
	// run needs about 11.5k cycles
	initial begin
		#200000;
		fails++;
		stop_test();
	end
endmodule
`default_nettype wire
